/* File: src/pia_pkg.sv */
// package for the priority interrupt acceptor and its cpu-side partner
// assumes one clock domain shared by both ends
package pia_pkg;
	localparam int PIA_NUM_SRC = 8;
	localparam int PIA_LVL_W = 4;
	localparam int PIA_IDX_W = 3;
	localparam logic [3:0] PIA_LVL_ZERO = 4'h0;
	localparam logic [3:0] PIA_MASK_RESET = 4'hf;
	localparam logic [2:0] PIA_IDX_ZERO = 3'h0;
	localparam logic [7:0] PIA_VEC_BASE = 8'h40;
	typedef enum logic [2:0] {
		PIA_IDLE = 3'b001,
		PIA_WAIT = 3'b010,
		PIA_MASK = 3'b100
	} pia_state_t;
endpackage

/* File: src/pia_link_if.sv */
// link between the interrupt acceptor and the cpu core
// assumes both ends share clk_sys
`timescale 1ns/10ps
interface pia_link_if;
	logic irq_req;
	logic [3:0] irq_level;
	logic [2:0] irq_index;
	logic irq_edge;
	logic irq_taken;
	logic mask_loaded;
	logic [3:0] cpu_level_mask;
	modport acceptor (output irq_req, output irq_level, output irq_index, output irq_edge,
		input irq_taken, input mask_loaded, input cpu_level_mask);
	modport cpu (input irq_req, input irq_level, input irq_index, input irq_edge,
		output irq_taken, output mask_loaded, output cpu_level_mask);
endinterface

/* File: src/pia_acceptor.sv */
// interrupt acceptor: picks highest pending source, compares with cpu mask
// assumes sources are synchronous to clk_sys and held until serviced
`timescale 1ns/10ps
module pia_acceptor
	import pia_pkg::*;
#(
	parameter int NUM_SRC = PIA_NUM_SRC
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic [NUM_SRC-1:0] src_req,
	input wire logic [NUM_SRC-1:0] src_is_edge,
	input wire logic [NUM_SRC*4-1:0] source_priority_settings_low,
	output logic accept_indicator_n,
	output logic [NUM_SRC-1:0] src_ack,
	pia_link_if.acceptor link
);
	pia_state_t state, next_state;
	logic [3:0] best_lvl;
	logic [2:0] best_idx;
	logic best_any;
	logic [3:0] cur_lvl, next_cur_lvl;
	logic [2:0] cur_idx, next_cur_idx;
	logic cur_edge, next_cur_edge;
	logic ind_n, next_ind_n;
	logic [NUM_SRC-1:0] ack, next_ack;
	logic req, next_req;

	// priority pick: strictly greater wins so lower index keeps ties
	always_comb begin
		best_lvl = PIA_LVL_ZERO;
		best_idx = PIA_IDX_ZERO;
		best_any = 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (src_req[i] && source_priority_settings_low[i*4 +: 4] > best_lvl) begin
				best_lvl = source_priority_settings_low[i*4 +: 4];
				best_idx = 3'(i);
				best_any = 1'b1;
			end
		end
	end

	// acceptance sequencer
	always_comb begin
		next_state = state;
		next_cur_lvl = cur_lvl;
		next_cur_idx = cur_idx;
		next_cur_edge = cur_edge;
		next_ind_n = ind_n;
		next_ack = '0;
		next_req = req;
		case (state)
			PIA_IDLE: begin
				if (best_any && best_lvl > link.cpu_level_mask) begin
					next_state = PIA_WAIT;
					next_cur_lvl = best_lvl;
					next_cur_idx = best_idx;
					next_cur_edge = src_is_edge[best_idx];
					next_ind_n = 1'b0;
					next_req = 1'b1;
				end
			end
			PIA_WAIT: begin
				if (link.irq_taken) begin
					next_req = 1'b0;
					next_ack[cur_idx] = 1'b1;
					if (cur_edge) begin
						next_ind_n = 1'b1;
						next_state = PIA_IDLE;
					end else begin
						next_state = PIA_MASK;
					end
				end else if (best_any && best_lvl > cur_lvl) begin
					next_cur_lvl = best_lvl;
					next_cur_idx = best_idx;
					next_cur_edge = src_is_edge[best_idx];
				end
			end
			PIA_MASK: begin
				if (link.mask_loaded) begin
					next_state = PIA_IDLE;
					// a higher request already above the new mask keeps the pin low
					if (best_any && best_lvl > cur_lvl) begin
						next_ind_n = 1'b0;
					end else begin
						next_ind_n = 1'b1;
					end
				end
			end
			default: next_state = PIA_IDLE;
		endcase
	end

	// register sequencer state
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state <= PIA_IDLE;
			cur_lvl <= PIA_LVL_ZERO;
			cur_idx <= PIA_IDX_ZERO;
			cur_edge <= 1'b0;
			ind_n <= 1'b1;
			ack <= '0;
			req <= 1'b0;
		end else begin
			state <= next_state;
			cur_lvl <= next_cur_lvl;
			cur_idx <= next_cur_idx;
			cur_edge <= next_cur_edge;
			ind_n <= next_ind_n;
			ack <= next_ack;
			req <= next_req;
		end
	end

	assign accept_indicator_n = ind_n;
	assign src_ack = ack;
	assign link.irq_req = req;
	assign link.irq_level = cur_lvl;
	assign link.irq_index = cur_idx;
	assign link.irq_edge = cur_edge;
endmodule

/* File: src/pia_cpu_end.sv */
// cpu-side end: takes requests at decode, runs exception entry steps
// assumes the acceptor holds irq_req until irq_taken
`timescale 1ns/10ps
module pia_cpu_end
	import pia_pkg::*;
(
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic decode_valid,
	input wire logic [3:0] mask_write_value,
	input wire logic mask_write,
	output logic stack_push,
	output logic vector_fetch,
	output logic [7:0] vector_addr,
	output logic [3:0] cpu_status_word,
	pia_link_if.cpu link
);
	logic taken, next_taken;
	logic push, next_push;
	logic loaded, next_loaded;
	logic fetch, next_fetch;
	logic [7:0] vaddr, next_vaddr;
	logic [3:0] mask, next_mask;

	// exception entry: take, push, load mask and fetch vector
	always_comb begin
		next_taken = 1'b0;
		next_push = taken;
		next_loaded = push;
		next_fetch = loaded;
		next_vaddr = vaddr;
		next_mask = mask;
		if (link.irq_req && decode_valid && !taken && !push && !loaded) begin
			next_taken = 1'b1;
		end
		if (push) begin
			next_mask = link.irq_level;
			next_vaddr = PIA_VEC_BASE + {5'h00, link.irq_index};
		end else if (mask_write) begin
			next_mask = mask_write_value;
		end
	end

	// register entry steps; vector fetch is the last step
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			taken <= 1'b0;
			push <= 1'b0;
			loaded <= 1'b0;
			fetch <= 1'b0;
			vaddr <= PIA_VEC_BASE;
			mask <= PIA_MASK_RESET;
		end else begin
			taken <= next_taken;
			push <= next_push;
			loaded <= next_loaded;
			fetch <= next_fetch;
			vaddr <= next_vaddr;
			mask <= next_mask;
		end
	end

	assign link.irq_taken = taken;
	assign link.mask_loaded = loaded;
	assign link.cpu_level_mask = mask;
	assign stack_push = push;
	assign vector_fetch = fetch;
	assign vector_addr = vaddr;
	assign cpu_status_word = mask;
endmodule

/* File: sim/pia_sva.sv */
// link checker for acceptor and cpu end
// assumes it sits beside pia_link_if on clk_sys
`timescale 1ns/10ps
module pia_sva (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic irq_req,
	input wire logic [3:0] irq_level,
	input wire logic [2:0] irq_index,
	input wire logic irq_edge,
	input wire logic irq_taken,
	input wire logic mask_loaded,
	input wire logic [3:0] cpu_level_mask
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// request, take and mask load relations
	a_req_above_mask: assert property (irq_req && !irq_taken |-> irq_level > cpu_level_mask) else $error("low req");
	a_req_nonzero: assert property (irq_req |-> irq_level != 4'h0) else $error("zero req");
	a_req_holds: assert property (irq_req && !irq_taken |=> irq_req) else $error("req dropped");
	a_req_ends: assert property (irq_taken |=> !irq_req) else $error("req kept");
	a_taken_cause: assert property (irq_taken |-> $past(irq_req)) else $error("stray take");
	a_mask_loads: assert property (irq_taken |-> ##2 mask_loaded && cpu_level_mask == $past(irq_level, 2))
		else $error("mask not loaded");
	a_mask_cause: assert property (mask_loaded |-> $past(irq_taken, 2)) else $error("stray load");
	a_level_upgrade: assert property (irq_req && $past(irq_req) && !$past(irq_taken) |-> irq_level >= $past(irq_level))
		else $error("level fell");
	// main scenarios
	cover property (irq_taken && irq_edge);
	cover property (irq_taken && !irq_edge);
	cover property (irq_taken && irq_index == 3'h7);
	cover property (irq_req && $past(irq_req) && irq_level > $past(irq_level));
endmodule

/* File: sim/pia_acceptor_tb.sv */
// bench joining acceptor and cpu end through pia_link_if
// assumes the design files in src/ are compiled first
`timescale 1ns/10ps
module pia_acceptor_tb;
	import pia_pkg::*;
	logic clk_sys = 0, resetn = 0, decode_valid = 1, mask_write = 0, accept_indicator_n, stack_push, vector_fetch;
	logic [3:0] mask_write_value = 4'h0, cpu_status_word;
	logic [7:0] src_req = 8'h00, src_is_edge = 8'h10, src_ack, vector_addr;
	logic [31:0] source_priority_settings_low = 32'h9007_0370;
	int failures = 0, checks = 0, cycles = 0;
	pia_link_if link ();
	pia_acceptor u_pia_acceptor (.clk_sys, .resetn, .src_req, .src_is_edge, .source_priority_settings_low,
		.accept_indicator_n, .src_ack, .link);
	pia_cpu_end u_pia_cpu_end (.clk_sys, .resetn, .decode_valid, .mask_write_value, .mask_write,
		.stack_push, .vector_fetch, .vector_addr, .cpu_status_word, .link);
	pia_sva u_pia_sva (.clk_sys, .resetn, .irq_req(link.irq_req), .irq_level(link.irq_level),
		.irq_index(link.irq_index), .irq_edge(link.irq_edge), .irq_taken(link.irq_taken),
		.mask_loaded(link.mask_loaded), .cpu_level_mask(link.cpu_level_mask));
	// clock and hang guard
	always #2 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
		chk({7'h00, accept_indicator_n}, 8'h01);
	endtask
	task automatic setm(input logic [3:0] v);
		@(negedge clk_sys);
		mask_write_value = v;
		mask_write = 1;
		@(negedge clk_sys);
		mask_write = 0;
	endtask
	// waits for one acceptance and follows its entry steps
	task automatic run(input int idx, input logic [3:0] lvl, input logic edg);
		int n;
		n = 0;
		while (src_ack === 8'h00 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		chk(src_ack, 8'(1 << idx));
		chk({accept_indicator_n, stack_push}, {edg, 1'b1});
		src_req = src_req & ~src_ack;
		@(negedge clk_sys);
		chk(accept_indicator_n, edg);
		@(negedge clk_sys);
		chk({accept_indicator_n, vector_fetch, cpu_status_word}, {2'b11, lvl});
		chk(vector_addr, 8'(PIA_VEC_BASE + idx));
	endtask
	task automatic t_tie;
		src_req = 8'h13;
		idle(6);
		chk(cpu_status_word, PIA_MASK_RESET);
		setm(4'h0);
		run(1, 4'h7, 0);
		idle(6);
		setm(4'h6);
		run(4, 4'h7, 1);
		setm(4'h0);
		idle(6);
		$display("tie done");
	endtask
	task automatic t_high;
		src_req = src_req | 8'h84;
		run(7, 4'h9, 0);
		idle(6);
		setm(4'h0);
		run(2, 4'h3, 0);
		$display("high done");
	endtask
	// cpu stalled in decode: a higher source arriving while held replaces the held one
	task automatic t_upgrade;
		decode_valid = 0;
		setm(4'h0);
		src_req = src_req | 8'h04;
		repeat (3) @(negedge clk_sys);
		chk({7'h00, accept_indicator_n}, 8'h00);
		chk(src_ack, 8'h00);
		src_req = src_req | 8'h80;
		repeat (2) @(negedge clk_sys);
		chk({7'h00, accept_indicator_n}, 8'h00);
		chk(src_ack, 8'h00);
		decode_valid = 1;
		run(7, 4'h9, 0);
		setm(4'h0);
		run(2, 4'h3, 0);
		$display("upgrade done");
	endtask
	task automatic results;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge clk_sys);
		resetn = 1;
		t_tie();
		t_high();
		t_upgrade();
		results();
	end
endmodule
